/* cml_cfg.svh */
// Offsets, command codes, field positions and fixed values of the lock block
`ifndef CML_CFG_SVH
`define CML_CFG_SVH
`define CML_OFS_ADDR    12'h000
`define CML_OFS_WDATA   12'h004
`define CML_OFS_CMD     12'h008
`define CML_OFS_RESULT  12'h00c
`define CML_OFS_STATUS  12'h010
`define CML_CMD_PROGRAM_STROBE    3'h1
`define CML_CMD_PROGENC 3'h2
`define CML_CMD_LOCK    3'h3
`define CML_CMD_ERASE   3'h4
`define CML_CMD_VERIFY  3'h5
`define CML_CMD_SIG     3'h6
`define CML_SIG_LOC0    8'h30
`define CML_SIG_LOC1    8'h31
`define CML_SIG_LOC2    8'h60
`define CML_ERASED      8'hff
`define CML_VERIFY_OFF  8'hff
`define CML_SIG_MISS    8'hff
`define CML_ENC_AW      6
`define CML_EA_BOOT     2'h2
`define CML_LOCK_NONE   3'h0
`define CML_LOCK_ONE    3'h1
`define CML_LOCK_TWO    3'h3
`define CML_LOCK_ALL    3'h7
`endif

/* cml_pkg.sv */
// Types shared by the lock block and its bus
package cml_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cml_apb_req_t;

  typedef enum logic [1:0] {
    LVL_OPEN,
    LVL_NO_EXT_READ,
    LVL_NO_VERIFY,
    LVL_NO_EXT_EXEC
  } cml_level_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  result;
    logic        refused;
    logic [2:0]  lock;
    logic        ea_s1;
    logic        ea_s2;
    logic        ea_lat;
    logic        ea_caught;
    logic [1:0]  boot_cnt;
    logic [31:0] prdata;
  } cml_state_t;
endpackage

/* cml_lock_ctrl.sv */
// Code memory lock and protection logic with APB register access
`timescale 1ns/1ns
`default_nettype none
`include "cml_cfg.svh"

// How it works
// R1 - three protection bits select protection level
// R2 - any lock bit refuses programming; erase keeps locks
// R3 - three signature bytes read at 30h, 31h, 60h
// R4 - no locks: no protection, verify still encrypted
// R5 - bit one: block external table reads, latch access
// R6 - bits one and two: also verify disabled
// R7 - all bits: also external execution blocked
// R8 - other lock patterns undefined, programmer avoids
// R9 - erased array reads all ones
// R10 - verify byte is code XNOR encryption byte
module cml_lock_ctrl #(
  parameter int         ADDR_W    = 14,
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h7e  // Arbitrary identity value
) (
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  input  wire cml_pkg::cml_apb_req_t apb_in,
  output logic [31:0]                prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  input  wire logic                  external_access_select_in,
  input  wire logic                  code_table_read_ext_in,
  input  wire logic                  ext_exec_in,
  output logic                       table_read_block_out,
  output logic                       ext_exec_block_out,
  output logic                       ea_effective_out,
  output logic [1:0]                 level_out
);
  import cml_pkg::*;

  localparam int DEPTH     = 1 << ADDR_W;
  localparam int ENC_DEPTH = 1 << `CML_ENC_AW;

  cml_state_t q;
  cml_state_t d;
  cml_level_t level;
  logic [7:0] code_mem [DEPTH];
  logic [7:0] enc_mem  [ENC_DEPTH];
  logic       access;
  logic       wr;
  logic       cmd_go;
  logic [2:0] cmd;
  logic       program_strobe_we;
  logic       enc_we;
  logic       erase;
  logic [7:0] code_byte;
  logic [7:0] vbyte;
  logic [7:0] sig_byte;

  // Address decode, shared by write path and error answer
  function automatic logic reg_hit(input logic [11:0] a);
    if (a == `CML_OFS_ADDR) begin
      return 1'b1;
    end else if (a == `CML_OFS_WDATA) begin
      return 1'b1;
    end else if (a == `CML_OFS_CMD) begin
      return 1'b1;
    end else if (a == `CML_OFS_RESULT) begin
      return 1'b1;
    end else if (a == `CML_OFS_STATUS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // Unlisted patterns map to the strongest level, the safe side
  function automatic cml_level_t lock_level(input logic [2:0] lb);
    case (lb)
      `CML_LOCK_NONE: return LVL_OPEN;        // R4
      `CML_LOCK_ONE:  return LVL_NO_EXT_READ; // R5
      `CML_LOCK_TWO:  return LVL_NO_VERIFY;   // R6
      `CML_LOCK_ALL:  return LVL_NO_EXT_EXEC; // R7
      default:        return LVL_NO_EXT_EXEC; // R8
    endcase
  endfunction

  assign level = lock_level(q.lock); // R1

  // Bus phases; zero wait states, so every access ends in one cycle
  assign access  = apb_in.psel & apb_in.penable;
  assign wr      = access & apb_in.pwrite & reg_hit(apb_in.paddr);
  assign cmd_go  = wr & (apb_in.paddr == `CML_OFS_CMD);
  assign cmd     = apb_in.pwdata[2:0];
  assign program_strobe_we = cmd_go & (cmd == `CML_CMD_PROGRAM_STROBE) & (q.lock == `CML_LOCK_NONE);    // R2
  assign enc_we  = cmd_go & (cmd == `CML_CMD_PROGENC) & (q.lock == `CML_LOCK_NONE); // R2
  assign erase   = cmd_go & (cmd == `CML_CMD_ERASE);

  // Verify path scrambles every byte with the encryption table
  assign code_byte = code_mem[q.addr[ADDR_W-1:0]];
  assign vbyte     = ~(code_byte ^ enc_mem[q.addr[`CML_ENC_AW-1:0]]); // R10

  // Signature lookup on the low address byte
  always_comb begin
    if (q.addr[7:0] == `CML_SIG_LOC0) begin
      sig_byte = SIG_BYTE0; // R3
    end else if (q.addr[7:0] == `CML_SIG_LOC1) begin
      sig_byte = SIG_BYTE1; // R3
    end else if (q.addr[7:0] == `CML_SIG_LOC2) begin
      sig_byte = SIG_BYTE2; // R3
    end else begin
      sig_byte = `CML_SIG_MISS;
    end
  end

  // Next state of all control, bus and pin-capture logic
  always_comb begin
    d       = q;
    d.ea_s1 = external_access_select_in;
    d.ea_s2 = q.ea_s1;
    // Strap capture waits for the synchroniser to hold a real sample
    if (q.boot_cnt != `CML_EA_BOOT) begin
      d.boot_cnt = q.boot_cnt + 2'h1;
    end else if (!q.ea_caught) begin
      d.ea_lat    = q.ea_s2; // R5
      d.ea_caught = 1'b1;
    end
    // Refused flag: clear first so a same-cycle refusal wins
    if (wr && apb_in.paddr == `CML_OFS_STATUS && apb_in.pwdata[0]) begin
      d.refused = 1'b0;
    end
    if (wr && apb_in.paddr == `CML_OFS_ADDR) begin
      d.addr = apb_in.pwdata[15:0];
    end
    if (wr && apb_in.paddr == `CML_OFS_WDATA) begin
      d.wdata = apb_in.pwdata[7:0];
    end
    if (cmd_go) begin
      case (cmd)
        `CML_CMD_PROGRAM_STROBE, `CML_CMD_PROGENC: begin
          if (q.lock != `CML_LOCK_NONE) begin
            d.refused = 1'b1; // R2
          end
        end
        `CML_CMD_LOCK: begin
          // Lock bits may still be added after the array is locked
          if (q.wdata[1:0] != 2'h0) begin
            d.lock[q.wdata[1:0] - 2'h1] = 1'b1; // R1
          end
        end
        `CML_CMD_VERIFY: begin
          if (level == LVL_NO_VERIFY || level == LVL_NO_EXT_EXEC) begin
            d.result  = `CML_VERIFY_OFF; // R6
            d.refused = 1'b1;
          end else begin
            d.result = vbyte; // R4
          end
        end
        `CML_CMD_SIG: begin
          d.result = sig_byte; // R3
        end
        default: begin
          d.result = q.result;
        end
      endcase
    end
    // Read data is taken in the setup cycle so it leaves a flop
    if (apb_in.psel && !apb_in.penable) begin
      if (apb_in.paddr == `CML_OFS_ADDR) begin
        d.prdata = {16'h0000, q.addr};
      end else if (apb_in.paddr == `CML_OFS_WDATA) begin
        d.prdata = {24'h000000, q.wdata};
      end else if (apb_in.paddr == `CML_OFS_RESULT) begin
        d.prdata = {24'h000000, q.result};
      end else if (apb_in.paddr == `CML_OFS_STATUS) begin
        d.prdata = {25'h0000000, ea_effective_out, level, q.lock, q.refused};
      end else begin
        d.prdata = 32'h00000000;
      end
    end
  end

  // State register; lock bits reset to the unprogrammed part
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Code and encryption storage; erase leaves lock bits alone
  always_ff @(posedge clk_in) begin
    if (erase) begin
      for (int i = 0; i < DEPTH; i++) begin
        code_mem[i] <= `CML_ERASED; // R9
      end
      for (int j = 0; j < ENC_DEPTH; j++) begin
        enc_mem[j] <= `CML_ERASED; // R9
      end
    end else if (program_strobe_we) begin
      code_mem[q.addr[ADDR_W-1:0]] <= q.wdata;
    end else if (enc_we) begin
      enc_mem[q.addr[`CML_ENC_AW-1:0]] <= q.wdata;
    end
  end

  // Gating toward the processor core
  assign table_read_block_out = code_table_read_ext_in & (level != LVL_OPEN); // R5
  assign ext_exec_block_out   = ext_exec_in & (level == LVL_NO_EXT_EXEC);    // R7
  assign ea_effective_out     = (level != LVL_OPEN && q.ea_caught) ? q.ea_lat : q.ea_s2; // R5
  assign level_out            = level;
  assign prdata_out           = q.prdata;
  assign pready_out           = 1'b1;
  assign pslverr_out          = access & ~reg_hit(apb_in.paddr);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  locked_refuse_a: assert property ((program_strobe_we | enc_we) |-> q.lock == `CML_LOCK_NONE) // R2
    else $error("programming accepted while locked");
  refuse_flag_a: assert property (cmd_go && cmd == `CML_CMD_PROGRAM_STROBE // R2
    && q.lock != `CML_LOCK_NONE |=> q.refused)
    else $error("locked program not flagged");
  erase_keep_a: assert property (erase |=> q.lock == $past(q.lock)) // R2
    else $error("erase changed lock bits");
  sig_read_a: assert property (cmd_go && cmd == `CML_CMD_SIG // R3
    && q.addr[7:0] == `CML_SIG_LOC1 |=> q.result == SIG_BYTE1)
    else $error("signature byte wrong");
  open_verify_a: assert property (cmd_go && cmd == `CML_CMD_VERIFY // R4
    && q.lock == `CML_LOCK_NONE |=> q.result == $past(vbyte))
    else $error("open verify wrong");
  table_block_a: assert property (code_table_read_ext_in && q.lock[0] // R5
    |-> table_read_block_out)
    else $error("external table read not blocked");
  verify_off_a: assert property (cmd_go && cmd == `CML_CMD_VERIFY // R6
    && (q.lock & `CML_LOCK_TWO) == `CML_LOCK_TWO
    |=> q.result == `CML_VERIFY_OFF && q.refused)
    else $error("verify not disabled");
  exec_block_a: assert property (ext_exec_in && q.lock == `CML_LOCK_ALL |-> ext_exec_block_out) // R7
    else $error("external execution not blocked");
  open_pass_a: assert property (q.lock == `CML_LOCK_NONE // R4
    |-> !table_read_block_out && !ext_exec_block_out)
    else $error("protection active with no locks");
  // An open verify up to 31 cycles after an erase, with no programming between, reads all ones
  erase_ones_a: assert property (erase ##1 ((!program_strobe_we && !enc_we) throughout // R9
    ##[0:30] (cmd_go && cmd == `CML_CMD_VERIFY && q.lock == `CML_LOCK_NONE))
    |=> q.result == `CML_ERASED)
    else $error("erased byte not all ones");
  ea_hold_a: assert property (q.ea_caught && q.lock[0] |-> ea_effective_out == q.ea_lat) // R5
    else $error("access select not latched");
endmodule
`default_nettype wire

/* cml_program_strobe_model.sv */
// Programmer model that issues APB register transfers to the lock block
`timescale 1ns/1ns
`default_nettype none
module cml_program_strobe_model (
  input  wire logic             clk_in,
  output var cml_pkg::cml_apb_req_t req_out,
  input  wire logic [31:0]      prdata_in,
  input  wire logic             pready_in,
  input  wire logic             pslverr_in
);
  import cml_pkg::*;
  logic err;
  initial begin
    req_out = '0;
    err = 1'b0;
  end
  // One transfer; the request is held until pready is seen high at an edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
    @(posedge clk_in);
    req_out <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    req_out.penable <= 1'b1;
    @(posedge clk_in);
    while (pready_in !== 1'b1) @(posedge clk_in);
    q = prdata_in;
    err = pslverr_in;
    req_out.psel <= 1'b0;
    req_out.penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the code memory lock block
`timescale 1ns/1ns
`default_nettype none
`include "cml_cfg.svh"
module tb;
  import cml_pkg::*;
  localparam logic [7:0] SIG0 = 8'h5a; // Arbitrary identity value
  localparam logic [7:0] SIG1 = 8'h3c; // Arbitrary identity value
  localparam logic [7:0] SIG2 = 8'h7e; // Arbitrary identity value
  logic         clk_in, arst_n_in, ea_pin, tbl_rd, ext_ex;
  logic         pready, pslverr, tbl_blk, ex_blk, ea_eff;
  logic [1:0]   level;
  logic [31:0]  prdata, q;
  cml_apb_req_t apb;
  int           fails, samples_checked, cycles;
  cml_lock_ctrl #(.ADDR_W(8), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) dut_u (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .apb_in(apb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .external_access_select_in(ea_pin),
    .code_table_read_ext_in(tbl_rd), .ext_exec_in(ext_ex), .table_read_block_out(tbl_blk),
    .ext_exec_block_out(ex_blk), .ea_effective_out(ea_eff), .level_out(level));
  cml_program_strobe_model program_strobe_u (.clk_in(clk_in), .req_out(apb), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr));
  // Free-running 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task print_verdict();
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data must land before the command word; result read after
  task run_cmd(input logic [15:0] a, input logic [7:0] d, input logic [2:0] c);
    program_strobe_u.xfer(1'b1, `CML_OFS_ADDR, {16'h0, a}, q);
    program_strobe_u.xfer(1'b1, `CML_OFS_WDATA, {24'h0, d}, q);
    program_strobe_u.xfer(1'b1, `CML_OFS_CMD, {29'h0, c}, q);
    program_strobe_u.xfer(1'b0, `CML_OFS_RESULT, 32'h0, q);
  endtask
  task rd_status();
    program_strobe_u.xfer(1'b0, `CML_OFS_STATUS, 32'h0, q);
  endtask
  // Core gating sampled one edge after the request lines settle
  task gates(input logic [1:0] lv, input logic tb_e, input logic ex_e);
    @(posedge clk_in);
    tbl_rd <= 1'b1;
    ext_ex <= 1'b1;
    @(posedge clk_in);
    chk({30'h0, level}, {30'h0, lv});
    chk({31'h0, tbl_blk}, {31'h0, tb_e});
    chk({31'h0, ex_blk}, {31'h0, ex_e});
  endtask
  // Pin moved, then read after the two-flop synchroniser has settled
  task ea_check(input logic pin, input logic exp);
    @(posedge clk_in);
    ea_pin <= pin;
    repeat (3) @(posedge clk_in);
    chk({31'h0, ea_eff}, {31'h0, exp});
  endtask
  task t_erase_open();
    run_cmd(16'h0005, 8'h00, `CML_CMD_ERASE);
    run_cmd(16'h0005, 8'h00, `CML_CMD_VERIFY);
    chk(q, 32'h0000_00ff);
    run_cmd(16'h0005, 8'ha5, `CML_CMD_PROGRAM_STROBE);
    run_cmd(16'h0005, 8'h00, `CML_CMD_VERIFY);
    chk(q, 32'h0000_00a5);
    run_cmd(16'h0005, 8'h0f, `CML_CMD_PROGENC);
    run_cmd(16'h0005, 8'h00, `CML_CMD_VERIFY);
    chk(q, 32'h0000_0055);
    gates(2'h0, 1'b0, 1'b0);
    ea_check(1'b0, 1'b0);
    ea_check(1'b1, 1'b1);
  endtask
  task t_signature();
    run_cmd({8'h0, `CML_SIG_LOC0}, 8'h00, `CML_CMD_SIG);
    chk(q, {24'h0, SIG0});
    run_cmd({8'h0, `CML_SIG_LOC1}, 8'h00, `CML_CMD_SIG);
    chk(q, {24'h0, SIG1});
    run_cmd({8'h0, `CML_SIG_LOC2}, 8'h00, `CML_CMD_SIG);
    chk(q, {24'h0, SIG2});
  endtask
  // Locks set only in the listed order, one bit at a time
  task t_locks();
    run_cmd(16'h0, 8'h01, `CML_CMD_LOCK);
    run_cmd(16'h0005, 8'h00, `CML_CMD_PROGRAM_STROBE);
    rd_status();
    chk(q, 32'h0000_0053);
    run_cmd(16'h0005, 8'h00, `CML_CMD_VERIFY);
    chk(q, 32'h0000_0055);
    gates(2'h1, 1'b1, 1'b0);
    ea_check(1'b0, 1'b1);
    ea_check(1'b1, 1'b1);
    run_cmd(16'h0, 8'h02, `CML_CMD_LOCK);
    run_cmd(16'h0005, 8'h00, `CML_CMD_VERIFY);
    chk(q, 32'h0000_00ff);
    gates(2'h2, 1'b1, 1'b0);
    run_cmd(16'h0, 8'h00, `CML_CMD_ERASE);
    rd_status();
    chk(q, 32'h0000_0067);
    run_cmd(16'h0, 8'h03, `CML_CMD_LOCK);
    gates(2'h3, 1'b1, 1'b1);
    program_strobe_u.xfer(1'b0, 12'h014, 32'h0, q);
    chk({31'h0, program_strobe_u.err}, 32'h1);
  endtask
  initial begin
    arst_n_in = 1'b0;
    ea_pin = 1'b1;
    tbl_rd = 1'b0;
    ext_ex = 1'b0;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_erase_open();
    t_signature();
    t_locks();
    print_verdict();
  end
endmodule
`default_nettype wire
